// ### verilog/aimap_pkg.sv
package aimap_pkg;
  // direct numbering bases, word offsets
  localparam logic [15:0] AIMAP_ALLOC_IN_BASE  = 16'h0000;
  localparam logic [15:0] AIMAP_CH12_BASE      = 16'h0200;
  localparam logic [15:0] AIMAP_CH34_BASE      = 16'h0280;
  localparam logic [15:0] AIMAP_STAT_WORD_BASE = 16'h0300;
  localparam logic [15:0] AIMAP_TYPE_BASE      = 16'h0400;
  localparam logic [15:0] AIMAP_HOLD_BASE      = 16'h0600;
  localparam logic [15:0] AIMAP_STAT_BIT_BASE  = 16'h0800;
  localparam logic [15:0] AIMAP_ALLOC_SPAN     = 16'h0200;
  // legacy prefixed numbering bases
  localparam logic [15:0] AIMAP_LEG_ALLOC_IN   = 16'h7531;
  localparam logic [15:0] AIMAP_LEG_HOLD       = 16'h3f48;
  localparam logic [15:0] AIMAP_LEG_CH12       = 16'h891c;
  localparam logic [15:0] AIMAP_LEG_CH34       = 16'h8a48;
  localparam logic [15:0] AIMAP_LEG_STAT_BIT   = 16'h36b1;
  localparam logic [15:0] AIMAP_LEG_STAT_WORD  = 16'h8980;
  localparam logic [15:0] AIMAP_LEG_TYPE       = 16'h89e4;
  // function codes and exception
  localparam logic [7:0]  AIMAP_FC_READ_BITS   = 8'h02;
  localparam logic [7:0]  AIMAP_FC_READ_HOLD   = 8'h03;
  localparam logic [7:0]  AIMAP_FC_READ_INPUT  = 8'h04;
  localparam logic [7:0]  AIMAP_EXC_ILL_ADDR   = 8'h02;
  // current in microamps, then channel and status bit counts
  localparam logic [15:0] AIMAP_LIVE_ZERO_UA   = 16'h0e10;
  localparam logic [15:0] AIMAP_LOW_POINT_UA   = 16'h03e8;
  localparam logic [15:0] AIMAP_HIGH_POINT_UA  = 16'h5208;
  localparam int          AIMAP_NUM_CH         = 4;
  localparam int          AIMAP_STAT_BITS      = 8;

  typedef struct packed {
    logic        valid;
    logic [7:0]  fc;
    logic        legacy;
    logic [15:0] addr;
  } aimap_req_t;

  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  exc_code;
    logic [15:0] data;
  } aimap_rsp_t;

  typedef struct packed {
    logic        fault_en;
    logic        scale_in_span;
    logic [15:0] low_point;
    logic [15:0] high_point;
    logic [8:0]  alloc_addr;
  } aimap_chcfg_t;

  typedef struct packed {
    aimap_rsp_t                   rsp;
    logic [AIMAP_NUM_CH-1:0]      chan_active;
    logic [AIMAP_STAT_BITS-1:0]   status;
  } aimap_state_t;
endpackage

// ### verilog/aimap_regs.sv
`timescale 1ns/1ps
// Behaviour
// - holding area at 1536 plus allocated address
// - slot words at 512, 640, 768, 1024
// - status bits at 2048 plus eight per slot
// - direct and legacy prefixed numbering both decode
// - broken lead or short gives line fault
// - line fault disableable per channel
// - configurable low and high switching points
// - live zero below 3.6 mA
// - channel active follows module active
// - word: live zero bit0, fault bit1, value above
// - scaling outside span: value only
module aimap_regs import aimap_pkg::*; #(
  parameter int          MAX_SLOTS = 64,
  parameter logic [15:0] TYPE_CODE = 16'h00a5  // arbitrary value
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           ce,
  // station configuration
  input  wire logic [5:0]                     my_slot,
  input  wire logic                           module_active,
  input  wire aimap_chcfg_t [AIMAP_NUM_CH-1:0] chan_cfg,
  // measurement from converter logic
  input  wire logic [AIMAP_NUM_CH-1:0][15:0]  chan_current,
  input  wire logic [AIMAP_NUM_CH-1:0][15:0]  chan_value,
  // read request and answer
  input  wire aimap_req_t                     req,
  output aimap_rsp_t                          rsp,
  output logic [AIMAP_NUM_CH-1:0]             chan_active
);

  if (MAX_SLOTS < 1 || MAX_SLOTS > 64) begin : g_chk
    $error("MAX_SLOTS must be 1..64");
  end

  aimap_state_t q;
  aimap_state_t d;
  logic [AIMAP_NUM_CH-1:0]       lz_c;
  logic [AIMAP_NUM_CH-1:0]       lf_c;
  logic [AIMAP_NUM_CH-1:0][15:0] word_c;
  logic [15:0]                   dir_c;

  // legacy base to direct base when inside span
  function automatic logic [15:0] leg_map(input logic [15:0] a, input logic [15:0] lb,
                                          input logic [15:0] db, input logic [15:0] span,
                                          input logic [15:0] dflt);
    leg_map = (a >= lb && a < lb + span) ? db + (a - lb) : dflt;
  endfunction

  function automatic logic [15:0] to_direct(input logic [15:0] a, input logic legacy);
    logic [15:0] r;
    logic [15:0] s;
    s = 16'(MAX_SLOTS);
    r = 16'hffff;
    if (!legacy) begin
      r = a;
    end else begin
      r = leg_map(a, AIMAP_LEG_ALLOC_IN, AIMAP_ALLOC_IN_BASE, AIMAP_ALLOC_SPAN, r);
      r = leg_map(a, AIMAP_LEG_HOLD, AIMAP_HOLD_BASE, AIMAP_ALLOC_SPAN, r);
      r = leg_map(a, AIMAP_LEG_CH12, AIMAP_CH12_BASE, 16'(2 * s), r);
      r = leg_map(a, AIMAP_LEG_CH34, AIMAP_CH34_BASE, 16'(2 * s), r);
      r = leg_map(a, AIMAP_LEG_STAT_WORD, AIMAP_STAT_WORD_BASE, s, r);
      r = leg_map(a, AIMAP_LEG_TYPE, AIMAP_TYPE_BASE, s, r);
      r = leg_map(a, AIMAP_LEG_STAT_BIT, AIMAP_STAT_BIT_BASE, 16'(8 * s), r);
    end
    to_direct = r;
  endfunction

  always_comb begin
    for (int i = 0; i < AIMAP_NUM_CH; i++) begin
      lz_c[i] = chan_current[i] < AIMAP_LIVE_ZERO_UA;
      lf_c[i] = chan_cfg[i].fault_en &&
                (chan_current[i] < chan_cfg[i].low_point ||
                 chan_current[i] > chan_cfg[i].high_point);
      word_c[i] = chan_cfg[i].scale_in_span ?
                  {chan_value[i][15:4], 2'b00, lf_c[i], lz_c[i]} :
                  chan_value[i];
    end
  end

  assign dir_c = to_direct(req.addr, req.legacy);

  always_comb begin
    logic        hit;
    logic [15:0] off;
    logic [15:0] dat;
    hit = 1'b0;
    off = 16'h0000;
    dat = 16'h0000;
    d = q;
    d.rsp.valid = 1'b0;
    d.chan_active = {AIMAP_NUM_CH{module_active}};
    d.status = {module_active, 3'b000, lf_c | lz_c};
    if (req.valid) begin
      unique case (req.fc)
        AIMAP_FC_READ_INPUT: begin
          if (dir_c < AIMAP_ALLOC_IN_BASE + AIMAP_ALLOC_SPAN) begin
            for (int i = 0; i < AIMAP_NUM_CH; i++) begin
              if (!hit && {7'h00, chan_cfg[i].alloc_addr} == dir_c - AIMAP_ALLOC_IN_BASE) begin
                hit = 1'b1;
                dat = word_c[i];
              end
            end
          end else if (dir_c >= AIMAP_CH12_BASE && dir_c < AIMAP_CH34_BASE) begin
            off = dir_c - AIMAP_CH12_BASE;
            hit = off[15:1] == {9'h000, my_slot};
            dat = off[0] ? word_c[1] : word_c[0];
          end else if (dir_c >= AIMAP_CH34_BASE && dir_c < AIMAP_STAT_WORD_BASE) begin
            off = dir_c - AIMAP_CH34_BASE;
            hit = off[15:1] == {9'h000, my_slot};
            dat = off[0] ? word_c[3] : word_c[2];
          end else if (dir_c >= AIMAP_STAT_WORD_BASE && dir_c < AIMAP_TYPE_BASE) begin
            hit = dir_c - AIMAP_STAT_WORD_BASE == {10'h000, my_slot};
            dat = {8'h00, d.status};
          end else if (dir_c >= AIMAP_TYPE_BASE && dir_c < AIMAP_HOLD_BASE) begin
            hit = dir_c - AIMAP_TYPE_BASE == {10'h000, my_slot};
            dat = TYPE_CODE;
          end
        end
        AIMAP_FC_READ_HOLD: begin
          if (dir_c >= AIMAP_HOLD_BASE && dir_c < AIMAP_HOLD_BASE + AIMAP_ALLOC_SPAN) begin
            for (int i = 0; i < AIMAP_NUM_CH; i++) begin
              if (!hit && {7'h00, chan_cfg[i].alloc_addr} == dir_c - AIMAP_HOLD_BASE) begin
                hit = 1'b1;
                dat = word_c[i];
              end
            end
          end
        end
        AIMAP_FC_READ_BITS: begin
          if (dir_c >= AIMAP_STAT_BIT_BASE) begin
            off = dir_c - AIMAP_STAT_BIT_BASE;
            hit = off[15:3] == {7'h00, my_slot};
            dat = {15'h0000, d.status[off[2:0]]};
          end
        end
        default: hit = 1'b0;
      endcase
      d.rsp.valid = 1'b1;
      d.rsp.exc = !hit;
      d.rsp.exc_code = hit ? 8'h00 : AIMAP_EXC_ILL_ADDR;
      d.rsp.data = hit ? dat : 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign rsp = q.rsp;
  assign chan_active = q.chan_active;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_hold_read_word: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_HOLD &&
      !req.legacy && req.addr == AIMAP_HOLD_BASE + {7'h00, chan_cfg[1].alloc_addr} &&
      chan_cfg[0].alloc_addr != chan_cfg[1].alloc_addr |=>
      rsp.valid && !rsp.exc && rsp.data == $past(word_c[1]))
    else $error("holding read wrong");
  a_slot_ch12_word: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      !req.legacy && req.addr == AIMAP_CH12_BASE + {9'h000, my_slot, 1'b1} |=>
      !rsp.exc && rsp.data == $past(word_c[1]))
    else $error("slot channel two read wrong");
  a_slot_ch34_word: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      !req.legacy && req.addr == AIMAP_CH34_BASE + {9'h000, my_slot, 1'b1} |=>
      !rsp.exc && rsp.data == $past(word_c[3]))
    else $error("slot channel four read wrong");
  a_status_word: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      !req.legacy && req.addr == AIMAP_STAT_WORD_BASE + {10'h000, my_slot} |=>
      !rsp.exc && rsp.data[15:7] == {8'h00, $past(module_active)} && rsp.data[6:4] == 3'b000)
    else $error("status word read wrong");
  a_status_bit_read: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_BITS &&
      !req.legacy && req.addr == AIMAP_STAT_BIT_BASE + {7'h00, my_slot, 3'b111} |=>
      !rsp.exc && rsp.data == {15'h0000, $past(module_active)})
    else $error("status bit read wrong");
  a_legacy_type_reg: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      req.legacy && req.addr == AIMAP_LEG_TYPE + {10'h000, my_slot} |=>
      !rsp.exc && rsp.data == TYPE_CODE)
    else $error("legacy type read wrong");
  a_legacy_alloc_in: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      req.legacy && req.addr == AIMAP_LEG_ALLOC_IN + {7'h00, chan_cfg[0].alloc_addr} |=>
      !rsp.exc && rsp.data == $past(word_c[0]))
    else $error("legacy allocated read wrong");
  a_fault_thresh: assert property (chan_cfg[3].fault_en &&
      chan_current[3] > chan_cfg[3].high_point |-> lf_c[3])
    else $error("short circuit not flagged");
  a_lead_break: assert property (chan_cfg[0].fault_en &&
      chan_current[0] < chan_cfg[0].low_point |-> lf_c[0])
    else $error("lead breakage not flagged");
  a_fault_off: assert property (!chan_cfg[1].fault_en |-> !lf_c[1])
    else $error("disabled channel flagged");
  a_live_zero_bit: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      !req.legacy && req.addr == AIMAP_CH12_BASE + {9'h000, my_slot, 1'b0} &&
      chan_cfg[0].scale_in_span |=>
      rsp.data[0] == ($past(chan_current[0]) < AIMAP_LIVE_ZERO_UA) && rsp.data[3:2] == 2'b00)
    else $error("live zero bit wrong");
  a_active_follow: assert property (ce ##1 ce |-> chan_active == {4{$past(module_active)}})
    else $error("channel active mismatch");
  a_value_only: assert property (!chan_cfg[2].scale_in_span |-> word_c[2] == chan_value[2])
    else $error("status bits not omitted");
  a_bad_read_exc: assert property (ce && req.valid && req.fc != AIMAP_FC_READ_BITS &&
      req.fc != AIMAP_FC_READ_HOLD && req.fc != AIMAP_FC_READ_INPUT |=>
      rsp.valid && rsp.exc && rsp.exc_code == AIMAP_EXC_ILL_ADDR && rsp.data == 16'h0000)
    else $error("bad function not rejected");
  a_foreign_slot: assert property (ce && req.valid && req.fc == AIMAP_FC_READ_INPUT &&
      !req.legacy && req.addr == AIMAP_STAT_WORD_BASE + {10'h000, my_slot} + 16'h0001 |=>
      rsp.valid && rsp.exc)
    else $error("foreign slot not rejected");
  a_exc_clean: assert property (rsp.valid && rsp.exc |->
      rsp.exc_code == AIMAP_EXC_ILL_ADDR && rsp.data == 16'h0000)
    else $error("exception answer not clean");
  a_ce_freeze: assert property (!ce |=> $stable(chan_active) && $stable(rsp))
    else $error("state moved while enable low");

  c_hold_read:  cover property (rsp.valid && !rsp.exc && $past(req.fc) == AIMAP_FC_READ_HOLD);
  c_legacy_bit: cover property (rsp.valid && !rsp.exc && $past(req.legacy));
  c_exception:  cover property (rsp.valid && rsp.exc);
  c_line_fault: cover property (lf_c[0] && lz_c[0]);
  c_enable_low: cover property (!ce ##1 !ce);
endmodule

// ### verification/aimap_master.sv
`timescale 1ns/1ps
module aimap_master import aimap_pkg::*; (
  // clock
  input  wire logic       clk,
  // request and answer
  output aimap_req_t      req,
  input  wire aimap_rsp_t rsp
);
  initial req = '0;
  // one strobe cycle, answer taken one edge later
  task automatic read(input logic [7:0] fc, input logic leg, input logic [15:0] a,
                      output aimap_rsp_t r);
    @(negedge clk);
    req = '{1'b1, fc, leg, a};
    @(negedge clk);
    req.valid = 1'b0;
    r = rsp;
  endtask
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb import aimap_pkg::*;;
  typedef struct packed {
    logic [7:0]  fc;
    logic        leg;
    logic [15:0] addr;
    logic [16:0] exp;
  } aimap_row_t;
  localparam logic [16:0] X = 17'h10000;
  logic               clk, reset, ce, mact;
  aimap_chcfg_t [3:0] cfg;
  logic [3:0][15:0]   cur, val;
  aimap_req_t         req;
  aimap_rsp_t         rsp, r;
  logic [3:0]         act;
  logic [7:0]         s;
  logic [15:0]        bnd [3] = '{16'h03e8, 16'h0e10, 16'h5209};
  int                 miscompares = 0, num_checks = 0;
  aimap_row_t         rows [20];

  aimap_regs aimap_regs_inst (.clk(clk), .reset(reset), .ce(ce), .my_slot(6'h05),
    .module_active(mact), .chan_cfg(cfg), .chan_current(cur), .chan_value(val),
    .req(req), .rsp(rsp), .chan_active(act));
  aimap_master aimap_master_inst (.clk(clk), .req(req), .rsp(rsp));

  function automatic logic [1:0] flt(int i);
    return {cfg[i].fault_en && (cur[i] < cfg[i].low_point || cur[i] > cfg[i].high_point),
            cur[i] < AIMAP_LIVE_ZERO_UA};
  endfunction
  function automatic logic [15:0] chw(int i);
    return cfg[i].scale_in_span ? {val[i][15:4], 2'b00, flt(i)} : val[i];
  endfunction
  function automatic logic [7:0] stb();
    return {mact, 3'b000, |flt(3), |flt(2), |flt(1), |flt(0)};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    mact = 1'b1;
    cfg[0] = '{1'b1, 1'b1, 16'h03e8, 16'h5208, 9'h003};
    cfg[1] = '{1'b0, 1'b1, 16'h03e8, 16'h5208, 9'h007};
    cfg[2] = '{1'b1, 1'b0, 16'h03e8, 16'h5208, 9'h010};
    cfg[3] = '{1'b1, 1'b1, 16'h03e8, 16'h5208, 9'h011};
    cur = {16'h55f0, 16'h2710, 16'h01f4, 16'h01f4};
    val = {16'hfff0, 16'h5a5a, 16'habcd, 16'h1234};
    #60 reset = 1'b0;
    s = stb();
    rows = '{
      '{8'h04, 1'b0, 16'h020a, {1'b0, chw(0)}},
      '{8'h04, 1'b0, 16'h020b, {1'b0, chw(1)}},
      '{8'h04, 1'b0, 16'h028a, {1'b0, chw(2)}},
      '{8'h04, 1'b0, 16'h028b, {1'b0, chw(3)}},
      '{8'h04, 1'b0, 16'h0305, {9'h0, s}},
      '{8'h04, 1'b0, 16'h0405, {1'b0, 16'h00a5}},
      '{8'h03, 1'b0, 16'h0607, {1'b0, chw(1)}},
      '{8'h04, 1'b0, 16'h0003, {1'b0, chw(0)}},
      '{8'h02, 1'b0, 16'h0828, {16'h0, s[0]}},
      '{8'h02, 1'b0, 16'h082a, {16'h0, s[2]}},
      '{8'h02, 1'b0, 16'h082f, {16'h0, s[7]}},
      '{8'h04, 1'b1, 16'h89e9, {1'b0, 16'h00a5}},
      '{8'h02, 1'b1, 16'h36e0, {16'h0, s[7]}},
      '{8'h04, 1'b1, 16'h8926, {1'b0, chw(0)}},
      '{8'h04, 1'b1, 16'h7534, {1'b0, chw(0)}},
      '{8'h03, 1'b1, 16'h3f4f, {1'b0, chw(1)}},
      '{8'h04, 1'b0, 16'h0306, X},
      '{8'h03, 1'b0, 16'h020a, X},
      '{8'h01, 1'b0, 16'h0000, X},
      '{8'h03, 1'b0, 16'h0609, X}};
    foreach (rows[i]) begin
      aimap_master_inst.read(rows[i].fc, rows[i].leg, rows[i].addr, r);
      check({r.valid, r.exc, r.data}, {1'b1, rows[i].exp});
      if (rows[i].exp[16]) check(r.exc_code, AIMAP_EXC_ILL_ADDR);
    end
    foreach (bnd[j]) begin
      @(negedge clk) cur[0] = bnd[j];
      aimap_master_inst.read(8'h04, 1'b0, 16'h020a, r);
      check({r.valid, r.exc, r.data}, {2'b10, chw(0)});
    end
    @(negedge clk) mact = 1'b0;
    repeat (2) @(negedge clk);
    check(act, 4'h0);
    aimap_master_inst.read(8'h04, 1'b0, 16'h0305, r);
    check(r.data, {8'h00, stb()});
    mact = 1'b1;
    repeat (2) @(negedge clk);
    check(act, 4'hf);
    ce = 1'b0;
    mact = 1'b0;
    repeat (2) @(negedge clk);
    check(act, 4'hf);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    check(act, 4'h0);
    mact = 1'b1;
    reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    check({act, rsp.valid, rsp.exc, rsp.data}, 24'h0);
    @(negedge clk);
    check(act, 4'hf);
    give_verdict();
  end
endmodule
